// *** core/eesl_pkg.sv ***
// constants and types shared by the two-wire serial memory slave
// assumes a single 100 MHz system clock and a synchronous active-high reset
package eesl_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_TIME_NS  = 4000000;
    // longest time, so rounded down
    localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          PROG_CNT_W    = 19;

    // ****************************************
    // array geometry and select byte
    // ****************************************
    localparam int          ARRAY_BYTES = 512;
    localparam int          PAGE_BYTES  = 16;
    localparam int          ADDR_W      = 9;
    localparam logic [3:0]  TYPE_MAIN   = 4'ha;
    localparam logic [3:0]  TYPE_ID     = 4'hb;

    // ****************************************
    // pin sampling
    // ****************************************
    localparam int          PIN_N          = 5;
    localparam int          PIN_SCL        = 0;
    localparam int          PIN_SDA        = 1;
    localparam int          PIN_WP         = 2;
    localparam int          PIN_STRAP_LOW  = 3;
    localparam int          PIN_STRAP_HIGH = 4;
    // bus lines idle high, straps and protect default low
    localparam logic [4:0]  PIN_RESET      = 5'h03;

    // ****************************************
    // wishbone register map
    // ****************************************
    localparam logic [31:0] REG_CTRL       = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS     = 32'h0000_0004;
    localparam int          CTRL_LOCK_BIT  = 0;
    localparam logic        LOCK_RESET     = 1'b0;

    typedef struct packed {
        logic [27:0] zero;
        logic        standby;
        logic        wp;
        logic        id_locked;
        logic        busy;
    } eesl_status_type;

    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK} eesl_state_type;
    typedef enum logic [1:0] {PH_DEV, PH_ADDR, PH_DATA} eesl_phase_type;

endpackage

// *** core/eesl_i2c_eeprom_slave.sv ***
// two-wire serial memory slave: 512 byte array, 16 byte pages, lockable id page
// assumes scl/sda/wp/straps arrive asynchronously and an external open-drain wire
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module eesl_i2c_eeprom_slave #(
    parameter int unsigned PROG_CYCLES = eesl_pkg::PROG_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        wp_i,
    input  wire logic        chip_select_strap_low_i,
    input  wire logic        chip_select_strap_high_i,
    output logic             standby_o,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // ****************************************
    // pin sampling
    // ****************************************
    logic [eesl_pkg::PIN_N-1:0] pin_raw;
    logic [eesl_pkg::PIN_N-1:0] pin_s1;
    logic [eesl_pkg::PIN_N-1:0] pin_s2;
    logic [eesl_pkg::PIN_N-1:0] pin_s3;
    logic [eesl_pkg::PIN_N-1:0] pin_q;

    assign pin_raw = {chip_select_strap_high_i, chip_select_strap_low_i, wp_i, sda_i, scl_i};

    // a change is taken only once two later stages agree, filtering glitches
    for (genvar g = 0; g < eesl_pkg::PIN_N; g++) begin : g_pin
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_s1[g] <= eesl_pkg::PIN_RESET[g];
                pin_s2[g] <= eesl_pkg::PIN_RESET[g];
                pin_s3[g] <= eesl_pkg::PIN_RESET[g];
                pin_q[g]  <= eesl_pkg::PIN_RESET[g];
            end else begin
                pin_s1[g] <= pin_raw[g];
                pin_s2[g] <= pin_s1[g];
                pin_s3[g] <= pin_s2[g];
                if (pin_s2[g] == pin_s3[g]) begin
                    pin_q[g] <= pin_s3[g];
                end
            end
        end
    end

    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    assign scl = pin_q[eesl_pkg::PIN_SCL];
    assign sda = pin_q[eesl_pkg::PIN_SDA];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign start_ev = scl && scl_d && sda_d && !sda;
    assign stop_ev  = scl && scl_d && !sda_d && sda;
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;

    // ****************************************
    // storage
    // ****************************************
    logic [7:0]  mem    [eesl_pkg::ARRAY_BYTES];
    logic [7:0]  id_mem [eesl_pkg::PAGE_BYTES];
    logic [7:0]  page_buf [eesl_pkg::PAGE_BYTES];
    logic [15:0] page_mask;
    logic [eesl_pkg::ADDR_W-1:0] ptr;
    logic        id_sel;
    logic        id_locked;
    logic        busy;
    logic        commit;
    logic        prog_start;
    logic        protect;
    logic [7:0]  rd_byte;
    logic [eesl_pkg::PROG_CNT_W-1:0] prog_cnt;

    assign rd_byte = id_sel ? id_mem[ptr[3:0]] : mem[ptr];
    assign protect = pin_q[eesl_pkg::PIN_WP] || (id_sel && id_locked);

    // ****************************************
    // bus engine
    // ****************************************
    eesl_pkg::eesl_state_type state;
    eesl_pkg::eesl_state_type after_ack;
    eesl_pkg::eesl_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic       blk;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state     <= eesl_pkg::ST_IDLE;
            after_ack <= eesl_pkg::ST_IDLE;
            phase     <= eesl_pkg::PH_DEV;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            blk       <= 1'b0;
            id_sel    <= 1'b0;
            ptr       <= 9'h000;
            page_mask <= 16'h0000;
            sda_oe_o  <= 1'b0;
        end else if (stop_ev) begin
            state    <= eesl_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (start_ev && !busy) begin
            state    <= eesl_pkg::ST_RECV;
            phase    <= eesl_pkg::PH_DEV;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
        end else begin
            if (commit) begin
                page_mask <= 16'h0000;
            end
            unique case (state)
                eesl_pkg::ST_IDLE: begin
                end
                eesl_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda};
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        unique case (phase)
                            eesl_pkg::PH_DEV: begin
                                if (shreg[7:5] == eesl_pkg::TYPE_MAIN[3:1] &&
                                    shreg[3:2] == {pin_q[eesl_pkg::PIN_STRAP_HIGH],
                                                   pin_q[eesl_pkg::PIN_STRAP_LOW]}) begin
                                    id_sel    <= shreg[4];
                                    blk       <= shreg[1];
                                    ptr[8]    <= shreg[4] ? ptr[8] : shreg[1];
                                    page_mask <= 16'h0000;
                                    sda_oe_o  <= 1'b1;
                                    state     <= eesl_pkg::ST_ACK;
                                    phase     <= eesl_pkg::PH_ADDR;
                                    after_ack <= shreg[0] ? eesl_pkg::ST_SEND : eesl_pkg::ST_RECV;
                                end else begin
                                    state <= eesl_pkg::ST_IDLE;
                                end
                            end
                            eesl_pkg::PH_ADDR: begin
                                ptr       <= {blk, shreg};
                                sda_oe_o  <= 1'b1;
                                state     <= eesl_pkg::ST_ACK;
                                phase     <= eesl_pkg::PH_DATA;
                                after_ack <= eesl_pkg::ST_RECV;
                            end
                            eesl_pkg::PH_DATA: begin
                                // refused byte is not acknowledged and ends the transfer
                                if (!protect) begin
                                    page_buf[ptr[3:0]]  <= shreg;
                                    page_mask[ptr[3:0]] <= 1'b1;
                                    ptr[3:0]            <= 4'(ptr[3:0] + 4'h1);
                                    sda_oe_o            <= 1'b1;
                                    state               <= eesl_pkg::ST_ACK;
                                    after_ack           <= eesl_pkg::ST_RECV;
                                end else begin
                                    state <= eesl_pkg::ST_IDLE;
                                end
                            end
                        endcase
                    end
                end
                eesl_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        state   <= after_ack;
                        if (after_ack == eesl_pkg::ST_SEND) begin
                            tx       <= rd_byte;
                            sda_oe_o <= !rd_byte[7];
                        end else begin
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                eesl_pkg::ST_SEND: begin
                    if (scl_rise) begin
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe_o <= 1'b0;
                            state    <= eesl_pkg::ST_MACK;
                        end else begin
                            tx       <= {tx[6:0], 1'b0};
                            sda_oe_o <= !tx[6];
                        end
                    end
                end
                eesl_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (sda) begin
                            state <= eesl_pkg::ST_IDLE;
                        end else begin
                            // sequential read; the id page wraps inside itself
                            ptr       <= id_sel ? {ptr[8:4], 4'(ptr[3:0] + 4'h1)}
                                                : 9'(ptr + 9'h001);
                            after_ack <= eesl_pkg::ST_SEND;
                            state     <= eesl_pkg::ST_ACK;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;  // open drain: only the enable ever changes
    end

    // ****************************************
    // self-timed programming
    // ****************************************
    assign prog_start = stop_ev && !busy && (page_mask != 16'h0000);
    assign commit     = busy && (prog_cnt == eesl_pkg::PROG_CNT_W'(PROG_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy     <= 1'b0;
            prog_cnt <= '0;
        end else if (prog_start) begin
            busy     <= 1'b1;
            prog_cnt <= '0;
        end else if (busy) begin
            if (commit) begin
                busy <= 1'b0;
            end else begin
                prog_cnt <= eesl_pkg::PROG_CNT_W'(prog_cnt + 1'b1);
            end
        end
    end

    // array is nonvolatile, so it is never reset
    always_ff @(posedge clk_i) begin
        if (commit) begin
            for (int i = 0; i < eesl_pkg::PAGE_BYTES; i++) begin
                if (page_mask[i]) begin
                    if (id_sel) begin
                        id_mem[i] <= page_buf[i];
                    end else begin
                        mem[{ptr[8:4], 4'(i)}] <= page_buf[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_o <= 1'b1;
        end else begin
            standby_o <= (state == eesl_pkg::ST_IDLE) && !busy && !prog_start;
        end
    end

    // ****************************************
    // wishbone registers
    // ****************************************
    eesl_pkg::eesl_status_type status;
    logic wb_req;

    assign wb_req           = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign status.zero      = '0;
    assign status.standby   = standby_o;
    assign status.wp        = pin_q[eesl_pkg::PIN_WP];
    assign status.id_locked = id_locked;
    assign status.busy      = busy;

    // lock is one-way: no write can clear it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_locked <= eesl_pkg::LOCK_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == eesl_pkg::REG_CTRL && wb_sel_i[0] &&
                     wb_dat_i[eesl_pkg::CTRL_LOCK_BIT]) begin
            id_locked <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i == eesl_pkg::REG_CTRL) begin
                    wb_dat_o <= {31'h0000_0000, id_locked};
                end else if (wb_adr_i == eesl_pkg::REG_STATUS) begin
                    wb_dat_o <= status;
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

endmodule

// *** verification/eesl_assertions.sv ***
// port checker for the two-wire serial memory slave
// assumes binding onto every eesl_i2c_eeprom_slave, one clock domain
`timescale 1ns/1ps
module eesl_assertions #(
    parameter int unsigned PROG_CYCLES = 50
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic        wp_i,
    input wire logic        chip_select_strap_low_i,
    input wire logic        chip_select_strap_high_i,
    input wire logic        standby_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    logic [31:0] low_cnt;
    logic        lock_seen;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ****************************************
    // helpers and properties
    // ****************************************
    // slack covers the longest transfer that also holds standby low
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_o) low_cnt <= 32'h0;
        else low_cnt <= low_cnt + 32'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) lock_seen <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
                 && wb_adr_i == eesl_pkg::REG_CTRL) lock_seen <= 1'b1;
    end
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !sda_oe_o && standby_o && !wb_ack_o) else $error("not quiet after reset");
    chk_drive_low: assert property (sda_oe_o |-> !sda_o)
        else $error("data driven high");
    chk_edge_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data moved while clock high");
    chk_standby_quiet: assert property (standby_o |-> !sda_oe_o)
        else $error("data driven in standby");
    chk_prog_bound: assert property (low_cnt < PROG_CYCLES + 8000)
        else $error("standby not regained in time");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given next cycle");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i != eesl_pkg::REG_CTRL && wb_adr_i != eesl_pkg::REG_STATUS
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_lock_sticky: assert property (wb_ack_o && !wb_we_i && lock_seen
        && wb_adr_i == eesl_pkg::REG_CTRL |-> wb_dat_o[0]) else $error("lock lost");
endmodule

bind eesl_i2c_eeprom_slave eesl_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .wp_i(wp_i), .chip_select_strap_low_i(chip_select_strap_low_i),
    .chip_select_strap_high_i(chip_select_strap_high_i), .standby_o(standby_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// *** verification/eesl_master_model.sv ***
// two-wire bus master model driving the clock and pulling the data wire
// assumes the data wire with its pull-up is resolved outside
`timescale 1ns/1ps
module eesl_master_model (
    input  wire logic  clk_i,
    input  wire logic  sda_i,
    output logic       scl_o,
    output logic       sda_oe_o,
    output logic       res_stb_o,
    output logic [8:0] res_val_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        res_stb_o = 1'b0;
        res_val_o = 9'h0;
    end
    // ****************************************
    // bus phases, data never moves near a clock edge
    // ****************************************
    task automatic step(input logic c, input logic d, input int n);
        scl_o <= c;
        sda_oe_o <= d;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic emit(input logic [8:0] v);
        res_val_o <= v;
        res_stb_o <= 1'b1;
        @(posedge clk_i);
        res_stb_o <= 1'b0;
    endtask
    // clock stands high between frames
    task automatic start();
        step(1'b0, sda_oe_o, 10);
        step(1'b0, 1'b0, 10);
        step(1'b1, 1'b0, 20);
        step(1'b1, 1'b1, 20);
    endtask
    task automatic stop();
        step(1'b0, sda_oe_o, 10);
        step(1'b0, 1'b1, 10);
        step(1'b1, 1'b1, 20);
        step(1'b1, 1'b0, 20);
    endtask
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, sda_oe_o, 10);
        step(1'b0, !b, 10);
        step(1'b1, !b, 10);
        s = sda_i;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic put(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        emit({!s, 8'h00});
    endtask
    task automatic get(input logic last);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
        emit({1'b0, d});
    endtask
endmodule

// *** verification/eesl_i2c_eeprom_slave_tb.sv ***
// self-checking bench: master model and wishbone driver around the slave
// assumes nothing outside; clock, reset and pull-up are made here
`timescale 1ns/1ps
module eesl_i2c_eeprom_slave_tb;
    localparam int unsigned PROG = 2000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wp = 1'b0;
    logic        s_lo = 1'b0;
    logic        s_hi = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0;
    logic [3:0]  wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack, sda_o, sda_oe, standby, scl, m_oe, res_stb;
    logic [8:0]  res_val;
    logic [7:0]  mem [0:527];
    logic [31:0] exp_q [$];
    int          bad_count = 0;
    int          checks = 0;
    wire         sda = (sda_oe ? sda_o : 1'b1) && !m_oe;
    eesl_i2c_eeprom_slave #(.PROG_CYCLES(PROG)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .wp_i(wp), .chip_select_strap_low_i(s_lo),
        .chip_select_strap_high_i(s_hi), .standby_o(standby), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack));
    eesl_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe),
        .res_stb_o(res_stb), .res_val_o(res_val));
    always #5 clk_i = ~clk_i;
    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic wrap_up();
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic guard(input logic ok);
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED %0t wait ran out", $time);
            wrap_up();
        end
    endtask
    always @(posedge clk_i) begin
        if (res_stb === 1'b1 || (wb_ack === 1'b1 && !wb_we)) begin
            guard(exp_q.size() > 0);
            check(res_stb ? {23'h0, res_val} : wb_dat_o, exp_q.pop_front());
        end
    end
    task automatic note(input logic [8:0] v);
        exp_q.push_back({23'h0, v});
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] e);
        int n;
        n = 0;
        if (!w) exp_q.push_back(e);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        guard(n < 20);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (standby !== 1'b1 && n < PROG + 200) begin
            @(posedge clk_i);
            n++;
        end
        guard(n < PROG + 200);
    endtask
    function automatic logic [7:0] sel(input logic id, input logic blk);
        return {3'b101, id, s_hi, s_lo, blk, 1'b0};
    endfunction
    // id page lives above the main array in the expected image
    function automatic int idx(input logic [7:0] s, input logic [7:0] a, input int i);
        logic [3:0] lo;
        lo = a[3:0] + 4'(i);
        return s[4] ? 512 + int'(lo) : int'({s[1], a[7:4], lo});
    endfunction
    task automatic probe(input logic [7:0] s, input logic ack);
        m.start();
        note({ack, 8'h00});
        m.put(s);
        m.stop();
    endtask
    task automatic open_at(input logic [7:0] s, input logic [7:0] a);
        m.start();
        note(9'h100);
        m.put(s);
        note(9'h100);
        m.put(a);
    endtask
    task automatic wr(input logic [7:0] s, input logic [7:0] a, input int n, input logic ok);
        logic [7:0] d;
        open_at(s, a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            note({ok, 8'h00});
            m.put(d);
            if (ok) mem[idx(s, a, i)] = d;
        end
        m.stop();
        if (ok) begin
            check(standby, 1'b0);
            probe(s, 1'b0);
            check(standby, 1'b0);
        end
        wait_idle();
    endtask
    task automatic rd(input logic [7:0] s, input logic [7:0] a, input int n);
        open_at(s, a);
        m.start();
        note(9'h100);
        m.put(s | 8'h01);
        for (int i = 0; i < n; i++) begin
            note({1'b0, mem[idx(s, a, i)]});
            m.get(i == n - 1);
        end
        m.stop();
    endtask
    initial begin
        void'($urandom(77127));
        {s_hi, s_lo} <= 2'($urandom);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, eesl_pkg::REG_STATUS, 32'h0, 32'h8);
        wb(1'b1, 32'h10, 32'hffff_ffff, 32'h0);
        wb(1'b0, 32'h10, 32'h0, 32'h0);
        wb(1'b0, eesl_pkg::REG_CTRL, 32'h0, 32'h0);
        probe(sel(1'b0, 1'b0) ^ 8'h08, 1'b0);
        wr(sel(1'b0, 1'b1), 8'h3e, 18, 1'b1);
        rd(sel(1'b0, 1'b1), 8'h30, 16);
        wr(sel(1'b0, 1'b1), 8'h33, 2, 1'b1);
        rd(sel(1'b0, 1'b1), 8'h30, 16);
        wp <= 1'b1;
        repeat (10) @(posedge clk_i);
        wb(1'b0, eesl_pkg::REG_STATUS, 32'h0, 32'hc);
        wr(sel(1'b0, 1'b1), 8'h35, 1, 1'b0);
        rd(sel(1'b0, 1'b1), 8'h34, 3);
        wp <= 1'b0;
        wr(sel(1'b1, 1'b0), 8'h04, 3, 1'b1);
        rd(sel(1'b1, 1'b0), 8'h04, 3);
        wb(1'b1, eesl_pkg::REG_CTRL, 32'h1, 32'h0);
        wb(1'b0, eesl_pkg::REG_CTRL, 32'h0, 32'h1);
        wb(1'b0, eesl_pkg::REG_STATUS, 32'h0, 32'ha);
        wr(sel(1'b1, 1'b0), 8'h05, 1, 1'b0);
        rd(sel(1'b1, 1'b0), 8'h04, 3);
        rst_i <= 1'b1;
        probe(sel(1'b0, 1'b0), 1'b0);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, eesl_pkg::REG_CTRL, 32'h0, 32'h0);
        probe(sel(1'b0, 1'b0), 1'b1);
        wait_idle();
        wrap_up();
    end
endmodule
